// ---- src/swic_cfg.svh ----
// Register offsets, field positions and reset values of the sleep/wake interrupt control block
`ifndef SWIC_CFG_SVH
`define SWIC_CFG_SVH

`define SWIC_CTRL_OFFSET     8'h2C
`define SWIC_CTRL_RESET      8'h00
`define SWIC_BIT_FIFO_GATE   7
`define SWIC_BIT_WAKE_TRANS  6
`define SWIC_BIT_WAKE_ORIENT 5
`define SWIC_BIT_WAKE_PULSE  4
`define SWIC_BIT_WAKE_FFMT   3
`define SWIC_BIT_WAKE_VECM   2
`define SWIC_BIT_IRQ_POL     1
`define SWIC_BIT_IRQ_DRIVE   0
`define SWIC_NUM_DET         5

`endif

// ---- src/swic_pkg.sv ----
// Types shared by the sleep/wake interrupt control block
package swic_pkg;
    // Gate state of the FIFO input
    typedef enum logic [0:0] {
        SWIC_GATE_OPEN,
        SWIC_GATE_FROZEN
    } swic_gate_e;
    // Control register image
    typedef logic [7:0] swic_reg_t;
endpackage

// ---- src/swic_sync3.sv ----
// Three-flop synchroniser for one pin input, change taken once flops two and three agree
`timescale 1ns/1ns
`default_nettype none
module swic_sync3
    import swic_pkg::*;
(
    input  wire logic clock_i,
    input  wire logic arst_n_i,
    input  wire logic din_i,
    output logic      dout_o
);
    // ------------------------------------------------------------
    // Synchroniser chain
    // ------------------------------------------------------------
    logic [2:0] chain_q;   // Flop chain
    logic [2:0] chain_d;   // Next chain
    logic       out_q;     // Filtered level
    logic       out_d;     // Next filtered level

    // Shift in and accept a change when flops two and three agree
    always_comb begin
        chain_d = {chain_q[1:0], din_i};
        out_d   = out_q;
        if (chain_q[1] == chain_q[2]) begin
            out_d = chain_q[2];
        end
    end

    // Register chain and output
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            chain_q <= 3'h0;
            out_q   <= 1'b0;
        end else begin
            chain_q <= chain_d;
            out_q   <= out_d;
        end
    end

    assign dout_o = out_q;
endmodule // swic_sync3
`default_nettype wire

// ---- src/swic_top.sv ----
// Sleep/wake FIFO gate, detector wake enables and interrupt pin drive control
`timescale 1ns/1ns
`default_nettype none
`include "swic_cfg.svh"

// What this block does
// - Gate off: flush FIFO on sleep/wake change
// - Gate on: keep FIFO, reject samples until emptied
// - Sample while frozen sets gate error flag
// - Emptying FIFO clears gate error flag
// - Flush FIFO on every data rate change
// - Bit 6 keeps transient detector on in sleep
// - Bit 5 keeps orientation detector on in sleep
// - Bit 4 keeps pulse detector on in sleep
// - Bit 3 keeps freefall/motion detector on in sleep
// - Bit 2 keeps vector-magnitude detector on in sleep
// - Bit 1 picks interrupt level, low default
// - Bit 0 picks push-pull or open drain
// - Sleep/wake change with auto-sleep enabled resets detector debounce counters
// - Auto-sleep enable gates sleep entry; clearing it forces wake
module swic_top
    import swic_pkg::*;
(
    input  wire logic       clock_i,          // 50 MHz device clock
    input  wire logic       arst_n_i,         // Asynchronous reset, active low
    input  wire logic       reg_wr_i,         // Register write strobe
    input  wire logic [7:0] reg_addr_i,       // Register address
    input  wire logic [7:0] reg_wdata_i,      // Register write data
    output logic      [7:0] reg_rdata_o,      // Register read data
    input  wire logic       auto_sleep_en_i,  // Auto-sleep enable from rate control
    input  wire logic       sleep_req_i,      // Sleep request from inactivity timer
    input  wire logic       odr_change_i,     // Pulse: output data rate changed
    input  wire logic       sample_valid_i,   // Pulse: new sample for the FIFO
    input  wire logic       fifo_empty_i,     // FIFO holds no samples
    input  wire logic [4:0] det_irq_i,        // Detector events, trans/orient/pulse/ffmt/vecm
    input  wire logic       irq_a_req_i,      // Routed interrupt request, line a
    input  wire logic       irq_b_req_i,      // Routed interrupt request, line b
    input  wire logic       irq_line_a_pin_i, // Pin level of line a
    input  wire logic       irq_line_b_pin_i, // Pin level of line b
    output logic            sample_accept_o,  // Sample may enter the FIFO
    output logic            fifo_flush_o,     // Pulse: flush the FIFO
    output logic            debounce_clr_o,   // Pulse: clear detector debounce counters
    output logic            sleep_mode_o,     // System is in sleep mode
    output logic            fgerr_o,          // Gate error flag of system mode status
    output logic      [4:0] det_enable_o,     // Detector run enables
    output logic            wake_o,           // Pulse: enabled detector woke the system
    output logic            irq_line_a_o,     // Line a output level
    output logic            irq_line_a_oe_o,  // Line a output enable
    output logic            irq_line_b_o,     // Line b output level
    output logic            irq_line_b_oe_o,  // Line b output enable
    output logic            irq_line_a_lvl_o, // Line a synchronised level
    output logic            irq_line_b_lvl_o  // Line b synchronised level
);
    // ------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------
    swic_reg_t ctrl_q;   // Control register image
    swic_reg_t ctrl_d;   // Next image
    logic      gate_en;  // FIFO gate enable bit
    logic      ipol;     // Interrupt polarity bit
    logic      drive_od; // Open drain select

    // Register write decode
    always_comb begin
        ctrl_d = ctrl_q;
        if (reg_wr_i && (reg_addr_i == `SWIC_CTRL_OFFSET)) begin
            ctrl_d = reg_wdata_i;
        end
    end

    // Register storage
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ctrl_q <= `SWIC_CTRL_RESET;
        end else begin
            ctrl_q <= ctrl_d;
        end
    end

    assign gate_en  = ctrl_q[`SWIC_BIT_FIFO_GATE];
    assign ipol     = ctrl_q[`SWIC_BIT_IRQ_POL];
    assign drive_od = ctrl_q[`SWIC_BIT_IRQ_DRIVE];

    // Read mux, unmapped addresses read zero
    always_comb begin
        reg_rdata_o = 8'h00;
        if (reg_addr_i == `SWIC_CTRL_OFFSET) begin
            reg_rdata_o = ctrl_q;
        end
    end

    // ------------------------------------------------------------
    // Sleep/wake mode, gate and error flag
    // ------------------------------------------------------------
    logic       sleep_q, sleep_d;   // Current system mode
    swic_gate_e gate_q, gate_d;     // FIFO input gate state
    logic       fgerr_q, fgerr_d;   // Gate error flag
    logic       flush_q, flush_d;   // Flush pulse
    logic       dbclr_q, dbclr_d;   // Debounce clear pulse
    logic       trans;              // Mode changes this cycle
    logic       wake_evt;           // Enabled detector fired in sleep

    assign wake_evt = sleep_q && (|(det_irq_i & det_enable_o));

    // Next mode, gate, flag and pulses
    always_comb begin
        sleep_d = sleep_q;
        if (!auto_sleep_en_i) begin
            sleep_d = 1'b0;
        end else if (sleep_q) begin
            sleep_d = !wake_evt;
        end else begin
            sleep_d = sleep_req_i;
        end
        trans   = (sleep_d != sleep_q);
        gate_d  = gate_q;
        fgerr_d = fgerr_q;
        flush_d = odr_change_i;
        dbclr_d = trans && auto_sleep_en_i;
        if (gate_q == SWIC_GATE_FROZEN) begin
            // Host drained the FIFO: reopen and clear the error
            if (fifo_empty_i) begin
                gate_d  = SWIC_GATE_OPEN;
                fgerr_d = 1'b0;
            end else if (sample_valid_i) begin
                fgerr_d = 1'b1;
            end
        end
        if (trans) begin
            if (gate_en) begin
                if (!fifo_empty_i) begin
                    gate_d = SWIC_GATE_FROZEN;
                end
            end else begin
                flush_d = 1'b1;
            end
        end
    end

    // Mode and gate registers
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            sleep_q <= 1'b0;
            gate_q  <= SWIC_GATE_OPEN;
            fgerr_q <= 1'b0;
            flush_q <= 1'b0;
            dbclr_q <= 1'b0;
        end else begin
            sleep_q <= sleep_d;
            gate_q  <= gate_d;
            fgerr_q <= fgerr_d;
            flush_q <= flush_d;
            dbclr_q <= dbclr_d;
        end
    end

    assign sample_accept_o = (gate_q == SWIC_GATE_OPEN);
    assign fifo_flush_o    = flush_q;
    assign debounce_clr_o  = dbclr_q;
    assign sleep_mode_o    = sleep_q;
    assign fgerr_o         = fgerr_q;
    assign wake_o          = wake_evt;

    // ------------------------------------------------------------
    // Detector enables, bits 6 down to 2
    // ------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < `SWIC_NUM_DET; gi++) begin : g_det
            // Detector runs in wake, or in sleep when its bit is set
            // Entry gi follows the event bit order, vector magnitude at 0, transient at 4
            assign det_enable_o[gi] = !sleep_q
                                      || ctrl_q[`SWIC_BIT_WAKE_VECM + gi];
        end
    endgenerate

    // ------------------------------------------------------------
    // Interrupt pin drivers
    // ------------------------------------------------------------
    // Asserted level follows polarity; open drain drives only that level
    assign irq_line_a_o    = irq_a_req_i ? ipol : !ipol;
    assign irq_line_b_o    = irq_b_req_i ? ipol : !ipol;
    assign irq_line_a_oe_o = !drive_od || irq_a_req_i;
    assign irq_line_b_oe_o = !drive_od || irq_b_req_i;

    // Pin readback through synchronisers
    swic_sync3 u_sync_a (
        .clock_i  (clock_i),
        .arst_n_i (arst_n_i),
        .din_i    (irq_line_a_pin_i),
        .dout_o   (irq_line_a_lvl_o)
    );
    swic_sync3 u_sync_b (
        .clock_i  (clock_i),
        .arst_n_i (arst_n_i),
        .din_i    (irq_line_b_pin_i),
        .dout_o   (irq_line_b_lvl_o)
    );

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!arst_n_i);

    flush_on_trans_a: assert property (trans && !gate_en |=> fifo_flush_o)
        else $error("no flush on mode change with gate off");
    freeze_on_trans_a: assert property (trans && gate_en && !fifo_empty_i
                                        |=> !sample_accept_o)
        else $error("fifo not frozen on gated change");
    fgerr_set_a: assert property (gate_q == SWIC_GATE_FROZEN && !fifo_empty_i
                                  && sample_valid_i |=> fgerr_o)
        else $error("gate error not set");
    fgerr_clear_a: assert property (fifo_empty_i && !sample_valid_i ##1 fifo_empty_i
                                    |=> !fgerr_o)
        else $error("gate error not cleared");
    odr_flush_a: assert property (odr_change_i |=> fifo_flush_o)
        else $error("no flush on rate change");
    sleep_disable_a: assert property (sleep_mode_o && !ctrl_q[`SWIC_BIT_WAKE_PULSE]
                                      |-> !det_enable_o[2])
        else $error("pulse detector runs in sleep");
    wake_enable_a: assert property (!sleep_mode_o |-> det_enable_o == 5'h1F)
        else $error("detector off in wake");
    irq_level_a: assert property (irq_line_a_oe_o && irq_a_req_i |-> irq_line_a_o == ipol)
        else $error("wrong asserted level");
    od_release_a: assert property (drive_od && !irq_b_req_i |-> !irq_line_b_oe_o)
        else $error("open drain drives idle level");
    no_sleep_a: assert property (!auto_sleep_en_i |=> !sleep_mode_o)
        else $error("sleep without auto-sleep");
    debounce_a: assert property (trans && auto_sleep_en_i |=> debounce_clr_o)
        else $error("debounce not cleared");

    cov_gate_c: cover property (trans && gate_en ##1 !sample_accept_o);
    cov_err_c: cover property (fgerr_o ##[1:20] !fgerr_o);
    cov_wake_c: cover property (wake_o);
endmodule // swic_top
`default_nettype wire

// ---- verification/swic_host_model.sv ----
// Host side model: FIFO fill count that the host drains
`timescale 1ns/1ns
`default_nettype none
module swic_host_model (
    input  wire logic clock_i,         // Device clock
    input  wire logic arst_n_i,        // Reset, active low
    input  wire logic sample_valid_i,  // Sample offered to FIFO
    input  wire logic sample_accept_i, // Gate lets it in
    input  wire logic fifo_flush_i,    // Flush pulse
    input  wire logic drain_i,         // Host reads one sample
    output logic      fifo_empty_o     // Nothing stored
);
    logic [5:0] count_q; // Stored samples
    logic [5:0] count_d; // Next count
    // Push, host read, flush wins
    always_comb begin
        count_d = count_q;
        if (sample_valid_i && sample_accept_i) begin
            count_d = count_d + 6'h01;
        end
        if (drain_i && count_q != 6'h00) begin
            count_d = count_d - 6'h01;
        end
        if (fifo_flush_i) begin
            count_d = 6'h00;
        end
    end
    // Count register
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            count_q <= 6'h00;
        end else begin
            count_q <= count_d;
        end
    end
    assign fifo_empty_o = (count_q == 6'h00);
endmodule // swic_host_model
`default_nettype wire

// ---- verification/sleep_wake_irq_control_bench.sv ----
// Self-checking bench of the sleep/wake interrupt control block
`timescale 1ns/1ns
`default_nettype none
module sleep_wake_irq_control_bench;
    logic clock_i = 1'b0, arst_n_i = 1'b0, wr = 1'b0, au = 1'b0, sr = 1'b0, rb = 1'b0;
    logic od = 1'b0, sv = 1'b0, rq = 1'b0, dr = 1'b0, acc, fl, dc, slp, fe, wk;
    logic la, ea, lb, eb, va, vb, emp;
    logic [7:0] ad = 8'h2C, wd = 8'h00, rd;
    logic [4:0] det = 5'h00, den;
    logic [4:0] rows [8] = '{5'h03, 5'h05, 5'h0A, 5'h17, 5'h11, 5'h0D, 5'h18, 5'h1F};
    logic [4:0] r; // Current row
    int num_errors = 0, compares = 0, cyc = 0;
    wire pa = ea ? la : 1'b1; // Pull-up on released line
    wire pb = eb ? lb : 1'b1;
    swic_top dut (.clock_i(clock_i), .arst_n_i(arst_n_i), .reg_wr_i(wr), .reg_addr_i(ad),
        .reg_wdata_i(wd), .reg_rdata_o(rd), .auto_sleep_en_i(au), .sleep_req_i(sr),
        .odr_change_i(od), .sample_valid_i(sv), .fifo_empty_i(emp), .det_irq_i(det),
        .irq_a_req_i(rq), .irq_b_req_i(rb), .irq_line_a_pin_i(pa), .irq_line_b_pin_i(pb),
        .sample_accept_o(acc), .fifo_flush_o(fl), .debounce_clr_o(dc), .sleep_mode_o(slp),
        .fgerr_o(fe), .det_enable_o(den), .wake_o(wk), .irq_line_a_o(la), .irq_line_a_oe_o(ea),
        .irq_line_b_o(lb), .irq_line_b_oe_o(eb), .irq_line_a_lvl_o(va), .irq_line_b_lvl_o(vb));
    swic_host_model host (.clock_i(clock_i), .arst_n_i(arst_n_i), .sample_valid_i(sv),
        .sample_accept_i(acc), .fifo_flush_i(fl), .drain_i(dr), .fifo_empty_o(emp));
    always #10 clock_i = ~clock_i;
    // Hang guard
    always @(posedge clock_i) begin
        cyc = cyc + 1;
        if (cyc == 3000) begin
            num_errors = num_errors + 1;
            conclude();
        end
    end
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic step(input int n);
        repeat (n) @(negedge clock_i);
    endtask
    task automatic chk(input string nm, input logic [7:0] ex, input logic [7:0] got);
        compares = compares + 1;
        if (got !== ex) begin
            num_errors = num_errors + 1;
            $display("BAD %s expected %h seen %h", nm, ex, got);
        end
    endtask
    task automatic wreg(input logic [7:0] a, input logic [7:0] d);
        wr = 1'b1; ad = a; wd = d; step(1); wr = 1'b0;
    endtask
    task automatic push2();
        sv = 1'b1; step(2); sv = 1'b0;
    endtask
    task automatic conclude();
        if (num_errors == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        step(10);
        chk("reset", 8'hFB, {rd == 8'h00, den == 5'h1F, acc, ea, eb, fl, la, lb});
        chk("reset_flags", 8'h00, {4'h0, slp, fe, dc, wk});
        step(10);
        arst_n_i = 1'b1;
        // Polarity and drive rows: {ipol, od, req, line, oe}
        for (int i = 0; i < 8; i++) begin
            r = rows[i];
            wreg(8'h2C, {1'b0, 5'h15, r[4:3]});
            rq = r[2];
            rb = r[2];
            step(6);
            chk("ctrl", {1'b0, 5'h15, r[4:3]}, rd);
            chk("pins", {4'h0, {2{r[1]}}, {2{r[0]}}}, {4'h0, la, lb, ea, eb});
            chk("lvl", {6'h00, {2{r[0] ? r[1] : 1'b1}}}, {6'h00, va, vb});
        end
        // Line b released while line a stays requested
        rb = 1'b0;
        step(1);
        chk("split", 8'h0C, {4'h0, la, ea, lb, eb});
        rq = 1'b0;
        wreg(8'h2D, 8'hFF);
        chk("unmapped", 8'h00, rd);
        ad = 8'h2C;
        step(1);
        chk("kept", 8'h57, rd);
        // Gate bypassed: sleep flushes
        wreg(8'h2C, 8'h00);
        au = 1'b1;
        push2();
        sr = 1'b1; step(1); sr = 1'b0;
        chk("to_sleep", 8'h1F, {acc, slp, fl, dc, den == 5'h00});
        step(1);
        chk("flushed", 8'h02, {emp, fl});
        wreg(8'h2C, 8'h58);
        chk("den", 8'h16, den);
        det = 5'h08; step(1); det = 5'h00;
        chk("no_wake", 8'h01, slp);
        push2();
        det = 5'h04; #1;
        chk("wake", 8'h01, wk);
        step(1); det = 5'h00;
        chk("woken", 8'h07, {slp, fl, dc, den == 5'h1F});
        // Gate on: freeze and error flag
        wreg(8'h2C, 8'h80);
        push2();
        sr = 1'b1; step(1); sr = 1'b0;
        chk("frozen", 8'h05, {acc, slp, fl, dc});
        sv = 1'b1; step(1); sv = 1'b0;
        chk("fgerr", 8'h01, {emp, fe});
        step(2);
        chk("held", 8'h01, {acc, fe});
        dr = 1'b1; step(2); dr = 1'b0;
        step(1);
        chk("thawed", 8'h02, {acc, fe});
        // Auto-sleep off forces wake; rate change flushes
        au = 1'b0; step(1);
        chk("wake_forced", 8'h04, {slp, acc, fl, dc});
        od = 1'b1; step(1); od = 1'b0;
        chk("odr", 8'h01, fl);
        step(1);
        chk("odr_end", 8'h00, fl);
        // Mid-run reset returns register and pins to defaults
        wreg(8'h2C, 8'h83);
        arst_n_i = 1'b0;
        step(2);
        chk("mid_reset", 8'h00, rd);
        chk("mid_pins", 8'h0F, {4'h0, la, ea, lb, eb});
        arst_n_i = 1'b1;
        wreg(8'h2C, 8'h02);
        chk("post_reset", 8'h05, {4'h0, la, ea, lb, eb});
        conclude();
    end
endmodule // sleep_wake_irq_control_bench
`default_nettype wire
